// File: rtl/pcs_pins.sv
// Purpose: control and status pin logic with an AHB-Lite register slave
// Assumes: all pin inputs are asynchronous to mclk_i
// Notes: open-drain pins drive low only; oe high means driving
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
module pcs_pins
   import pcs_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // pins
   input wire logic chip_reset_n_i,
   input wire logic mgmt_write_block_i,
   input wire logic supply_fault_i,
   input wire logic link_good_i,
   input wire logic link_gigabit_i,
   input wire logic activity_i,
   input wire logic low_power_request_n_i,
   output logic low_power_request_n_o,
   output logic low_power_request_n_oe_o,
   output logic supply_current_alarm_n_o,
   output logic supply_current_alarm_n_oe_o,
   input wire logic activity_indicator_i,
   output logic activity_indicator_o,
   output logic activity_indicator_oe_o,
   input wire logic gigabit_link_indicator_i,
   output logic gigabit_link_indicator_o,
   output logic gigabit_link_indicator_oe_o,
   input wire logic link_good_indicator_i,
   output logic link_good_indicator_o,
   output logic link_good_indicator_oe_o,
   output logic power_down_o,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [8:0] pins_raw;
   logic [8:0] pins_s;
   logic rst_n_s;
   logic wblock_s;
   logic sfault_s;
   logic lgood_s;
   logic lgig_s;
   logic act_s;
   logic pdreq_n_s;
   logic act_pin_s;
   logic straps_s;
   assign pins_raw = {low_power_request_n_i, activity_indicator_i, activity_i, link_gigabit_i,
                      link_good_i, supply_fault_i, mgmt_write_block_i, chip_reset_n_i,
                      1'b0};
   pcs_sync #(
      .W(9),
      .INIT(9'h102)
   ) u_sync (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pins_raw),
      .sync_o(pins_s)
   );
   assign rst_n_s = pins_s[1];
   assign wblock_s = pins_s[2];
   assign sfault_s = pins_s[3];
   assign lgood_s = pins_s[4];
   assign lgig_s = pins_s[5];
   assign act_s = pins_s[6];
   assign act_pin_s = pins_s[7];
   assign pdreq_n_s = pins_s[8];
   assign straps_s = pins_s[0];

   logic [2:0] led_s;
   pcs_sync #(
      .W(3),
      .INIT(3'h0)
   ) u_sync_led (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({activity_indicator_i, gigabit_link_indicator_i, link_good_indicator_i}),
      .sync_o(led_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // chip reset pulse qualification
   logic [3:0] rst_low_cnt;
   logic chip_rst_q;
   logic chip_rst_done;
   logic soft_rst;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rst_low_cnt <= 4'h0;
      end else if (rst_n_s) begin
         rst_low_cnt <= 4'h0;
      end else if (rst_low_cnt != 4'(RST_MIN_CYC)) begin
         rst_low_cnt <= rst_low_cnt + 4'h1;
      end
   end
   assign chip_rst_q = (rst_low_cnt == 4'(RST_MIN_CYC));
   assign soft_rst = sys_rst_i | chip_rst_q;
   logic chip_rst_d;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         chip_rst_d <= 1'b1;
      end else begin
         chip_rst_d <= chip_rst_q;
      end
   end
   assign chip_rst_done = chip_rst_d & ~chip_rst_q;

   ////////////////////////////////////////////////////////////////////////////
   // straps
   logic [2:0] strap_led;
   logic strap_wblock;
   logic [2:0] rst_hist;
   logic strap_take;
   logic strap_done;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rst_hist <= 3'h7;
      end else begin
         rst_hist <= {rst_hist[1:0], soft_rst};
      end
   end
   // two edges after release, so the strap levels have crossed the synchronisers
   assign strap_take = (rst_hist == 3'h4) & ~soft_rst;
   // led pins and write block sampled
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         strap_led <= 3'h0;
         strap_wblock <= 1'b0;
      end else if (strap_take) begin
         strap_led <= led_s;
         strap_wblock <= wblock_s;
      end
   end
   // indicators stay released until the straps are taken
   always_ff @(posedge mclk_i) begin
      if (soft_rst) begin
         strap_done <= 1'b0;
      end else if (strap_take) begin
         strap_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave
   logic dp_valid;
   logic dp_write;
   logic [7:0] dp_addr;
   logic req;
   logic wr_en;
   logic rd_en;
   assign req = hsel_i & hready_i & htrans_i[1];
   always_ff @(posedge mclk_i) begin
      if (soft_rst) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h0;
      end else begin
         dp_valid <= req;
         dp_write <= hwrite_i;
         dp_addr <= haddr_i;
      end
   end
   // writes blocked at 1
   // writes before the strap sample are dropped
   assign wr_en = dp_valid & dp_write & strap_done & ~strap_wblock;
   assign rd_en = dp_valid & ~dp_write;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   logic wr_ctrl;
   logic wr_mask;
   logic wr_iosel;
   logic rd_status;
   assign wr_ctrl = wr_en && (dp_addr == ADDR_CTRL);
   assign wr_mask = wr_en && (dp_addr == ADDR_MASK);
   assign wr_iosel = wr_en && (dp_addr == ADDR_IOSEL);
   assign rd_status = rd_en && (dp_addr == ADDR_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [1:0] ctrl;
   logic [EV_W-1:0] mask;
   logic [1:0] iosel;
   always_ff @(posedge mclk_i) begin
      if (soft_rst) begin
         ctrl <= CTRL_RESET;
         mask <= MASK_RESET;
         iosel <= IOSEL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= hwdata_i[1:0];
         end
         if (wr_mask) begin
            mask <= hwdata_i[EV_W-1:0];
         end
         if (wr_iosel) begin
            iosel <= hwdata_i[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] cause;
   logic lgood_d;
   logic pdreq_d;
   logic pd_pin_role;
   always_ff @(posedge mclk_i) begin
      if (soft_rst) begin
         lgood_d <= 1'b0;
         pdreq_d <= 1'b1;
      end else begin
         lgood_d <= lgood_s;
         pdreq_d <= pdreq_n_s;
      end
   end
   // with writes blocked the shared pin can only serve as the interrupt
   assign pd_pin_role = ~ctrl[CTRL_INT_ROLE] & ~strap_wblock;
   assign ev[EV_SUPPLY] = sfault_s & ~power_down_o;
   assign ev[EV_LINK] = lgood_s ^ lgood_d;
   assign ev[EV_PDREQ] = pd_pin_role & pdreq_d & ~pdreq_n_s;
   assign ev[EV_CHIPRST] = chip_rst_done;
   // sticky status bits, set beats read clear; cause keeps the last event set
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         status <= '0;
         cause <= '0;
      end else begin
         status <= (rd_status ? '0 : status) | ev;
         if (|ev) begin
            cause <= ev;
         end
      end
   end
   logic int_pending;
   assign int_pending = |(status & mask);

   ////////////////////////////////////////////////////////////////////////////
   // power state machine
   pcs_state_t state;
   pcs_state_t next_state;
   logic hold_start;
   logic hold_busy;
   logic pd_req;
   assign pd_req = (pd_pin_role & ~pdreq_n_s) | ctrl[CTRL_SW_PDOWN];
   assign hold_start = strap_wblock & (|ev) & (state == PCS_RUN);
   always_comb begin
      next_state = state;
      case (state)
         PCS_RUN: begin
            if (hold_start) begin
               next_state = PCS_HOLD_INT;
            end else if (pd_req) begin
               next_state = PCS_PDOWN;
            end
         end
         PCS_PDOWN: begin
            if (!pd_req) begin
               next_state = PCS_RUN;
            end
         end
         PCS_HOLD_INT: begin
            if (!hold_busy) begin
               next_state = PCS_RUN;
            end
         end
         default: begin
            next_state = PCS_RUN;
         end
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (soft_rst) begin
         state <= PCS_RUN;
      end else begin
         state <= next_state;
      end
   end
   pcs_hold_timer #(
      .CYC(HOLD_CYCLES)
   ) u_hold (
      .mclk_i(mclk_i),
      .sys_rst_i(soft_rst),
      .start_i(hold_start),
      .busy_o(hold_busy)
   );
   assign power_down_o = (state == PCS_PDOWN);
   assign irq_o = int_pending;

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers
   logic int_drive;
   logic alarm_drive;
   logic [2:0] led_val;
   assign int_drive = strap_wblock ? (state == PCS_HOLD_INT) : (~pd_pin_role & int_pending);
   assign alarm_drive = sfault_s & ~power_down_o;
   always_ff @(posedge mclk_i) begin
      if (soft_rst) begin
         led_val <= 3'h0;
         low_power_request_n_oe_o <= 1'b0;
         supply_current_alarm_n_oe_o <= 1'b0;
      end else begin
         led_val[0] <= lgood_s;
         led_val[1] <= lgood_s & lgig_s;
         led_val[2] <= (iosel == IOSEL_ACTIVITY) ? act_s : (iosel == IOSEL_OUT_HIGH);
         low_power_request_n_oe_o <= int_drive;
         supply_current_alarm_n_oe_o <= alarm_drive;
      end
   end
   assign low_power_request_n_o = 1'b0;
   assign supply_current_alarm_n_o = 1'b0;
   assign link_good_indicator_o = led_val[0];
   assign gigabit_link_indicator_o = led_val[1];
   assign activity_indicator_o = led_val[2];
   assign link_good_indicator_oe_o = strap_done;
   assign gigabit_link_indicator_oe_o = strap_done;
   assign activity_indicator_oe_o = strap_done & (iosel != IOSEL_INPUT);

   ////////////////////////////////////////////////////////////////////////////
   // read data
   logic [31:0] rdata;
   assign rdata = (dp_addr == ADDR_CTRL) ? {30'h0, ctrl} :
                  (dp_addr == ADDR_STATUS) ? {28'h0, status} :
                  (dp_addr == ADDR_MASK) ? {28'h0, mask} :
                  (dp_addr == ADDR_CAUSE) ? {28'h0, cause} :
                  (dp_addr == ADDR_STRAP) ? {28'h0, strap_wblock, strap_led} :
                  (dp_addr == ADDR_IOSEL) ? {29'h0, act_pin_s, iosel} :
                  (dp_addr == ADDR_STATE) ? {27'h0, straps_s, pdreq_n_s, state} :
                  32'h0;
   assign hrdata_o = rd_en ? rdata : 32'h0;
endmodule

// File: shared/pcs_pkg.sv
// Purpose: constants of the control and status pin block
// Assumes: mclk_i at 10 MHz, one aligned 32-bit word per register
// Notes: register offsets are byte addresses on the AHB-Lite slave
package pcs_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int RST_MIN_NS = 1000;
   localparam int RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int HOLD_MS = 500;
   localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_CAUSE = 8'h0c;
   localparam logic [7:0] ADDR_STRAP = 8'h10;
   localparam logic [7:0] ADDR_IOSEL = 8'h14;
   localparam logic [7:0] ADDR_STATE = 8'h18;
   // control fields
   localparam int CTRL_INT_ROLE = 0;
   localparam int CTRL_SW_PDOWN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // status and mask fields
   localparam int EV_W = 4;
   localparam int EV_SUPPLY = 0;
   localparam int EV_LINK = 1;
   localparam int EV_PDREQ = 2;
   localparam int EV_CHIPRST = 3;
   localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
   // io function select codes
   localparam logic [1:0] IOSEL_ACTIVITY = 2'h0;
   localparam logic [1:0] IOSEL_OUT_LOW = 2'h1;
   localparam logic [1:0] IOSEL_OUT_HIGH = 2'h2;
   localparam logic [1:0] IOSEL_INPUT = 2'h3;
   localparam logic [1:0] IOSEL_RESET = 2'h0;
   typedef enum logic [2:0] {
      PCS_RUN = 3'b001,
      PCS_PDOWN = 3'b010,
      PCS_HOLD_INT = 3'b100
   } pcs_state_t;
endpackage

// File: rtl/pcs_sync.sv
// Purpose: two flip-flop synchroniser per bit
// Assumes: inputs come from pins outside the mclk_i domain
// Notes: first stage is read only by the second stage
module pcs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] stage1;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stage1 <= INIT;
         sync_o <= INIT;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// File: rtl/pcs_hold_timer.sv
// Purpose: one-shot down counter for the self-clearing interrupt
// Assumes: start is a one-cycle pulse
// Notes: busy stays high for exactly CYC cycles after start
module pcs_hold_timer #(
   parameter int CYC = 5000000
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   output logic busy_o
);
   logic [31:0] count;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         count <= 32'h0;
      end else if (start_i) begin
         count <= 32'(CYC);
      end else if (count != 32'h0) begin
         count <= count - 32'h1;
      end
   end
   assign busy_o = (count != 32'h0);
endmodule

// File: bench/pcs_board.sv
// Purpose: board pull-ups, strap resistors and host pin drive
// Assumes: open-drain pins carry pull-ups
// Notes: strap levels show wherever an indicator is not driven
module pcs_board #(
   parameter logic [2:0] STRAP = 3'h5
) (
   input wire logic host_pd_i,
   input wire logic pin_oe_i,
   input wire logic [2:0] led_o_i,
   input wire logic [2:0] led_oe_i,
   output logic pin_n_o,
   output logic [2:0] led_i_o
);
   assign pin_n_o = !(pin_oe_i || host_pd_i);
   assign led_i_o = (led_oe_i & led_o_i) | (~led_oe_i & STRAP);
endmodule

// File: bench/pcs_pins_properties.sv
// Purpose: port properties of the pin block
// Assumes: zero-wait slave, pins settle within six cycles
// Notes: bound to every pcs_pins instance
module pcs_pins_chk
   import pcs_pkg::*;
#(
   parameter int HOLD_CYCLES = 50
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic mgmt_write_block_i,
   input wire logic supply_fault_i,
   input wire logic link_good_i,
   input wire logic link_gigabit_i,
   input wire logic low_power_request_n_o,
   input wire logic low_power_request_n_oe_o,
   input wire logic supply_current_alarm_n_o,
   input wire logic supply_current_alarm_n_oe_o,
   input wire logic activity_indicator_i,
   input wire logic gigabit_link_indicator_i,
   input wire logic link_good_indicator_i,
   input wire logic gigabit_link_indicator_o,
   input wire logic link_good_indicator_o,
   input wire logic power_down_o,
   input wire logic irq_o
);
   logic rd_now;
   logic [3:0] strap_q;
   int run_cnt;
   assign rd_now = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   // length of the current low pulse on the shared pin
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !low_power_request_n_oe_o) run_cnt <= 0;
      else run_cnt <= run_cnt + 1;
   end
   // strap copy taken at the first edge after reset
   always_ff @(posedge mclk_i) begin
      if ($past(sys_rst_i) && !sys_rst_i) strap_q <= {mgmt_write_block_i,
         activity_indicator_i, gigabit_link_indicator_i, link_good_indicator_i};
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus stalled or errored");
   a_alarm_set: assert property ((supply_fault_i && !power_down_o)[*6]
      |-> supply_current_alarm_n_oe_o) else $error("alarm not driven");
   a_alarm_free: assert property ((!supply_fault_i)[*6]
      |-> !supply_current_alarm_n_oe_o) else $error("alarm not released");
   a_od_low: assert property (!supply_current_alarm_n_o && !low_power_request_n_o)
      else $error("open drain driven high");
   a_link_led: assert property (($stable(link_good_i) && !power_down_o)[*6]
      |-> link_good_indicator_o == link_good_i) else $error("link indicator wrong");
   a_gig_led: assert property (($stable({link_good_i, link_gigabit_i}) && !power_down_o)[*6]
      |-> gigabit_link_indicator_o == (link_good_i && link_gigabit_i))
      else $error("gigabit indicator wrong");
   a_unmapped_zero: assert property (rd_now && haddr_i > 8'h1c |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_strap_read: assert property (rd_now && haddr_i == ADDR_STRAP
      |=> hrdata_o[3:0] == strap_q) else $error("strap read differs");
   a_state_hot: assert property (rd_now && haddr_i == ADDR_STATE
      |=> $onehot(hrdata_o[2:0]) && hrdata_o[1] == power_down_o) else $error("state bad");
   a_hold_bound: assert property (strap_q[3] |-> run_cnt <= HOLD_CYCLES + 1)
      else $error("interrupt held too long");
   a_reset_quiet: assert property ($fell(sys_rst_i) |-> !irq_o)
      else $error("interrupt after reset");
endmodule

bind pcs_pins pcs_pins_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.*);

// File: bench/pcs_pins_tb.sv
// Purpose: self-checking bench of the pin block
// Assumes: zero-wait slave, hold timer cut to 50 cycles
// Notes: read data is checked against a queue of notes
module pcs_pins_tb
   import pcs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HOLD = 50;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, dph = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic rst_n = 1'b1, wblk = 1'b0, fault = 1'b0, lgood = 1'b0, lgig = 1'b0, act = 1'b0;
   logic host_pd = 1'b0, hrdy, hresp, pin_o, pin_oe, pin_n, al_o, al_oe, pdn, irq;
   logic [2:0] led_o, led_oe, led_i;
   logic [63:0] notes[$];
   int n_mismatch = 0;
   int n_compared = 0;
   always #50 mclk_i = !mclk_i;
   pcs_pins #(.HOLD_CYCLES(HOLD)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
      .hresp_o(hresp), .chip_reset_n_i(rst_n), .mgmt_write_block_i(wblk),
      .supply_fault_i(fault), .link_good_i(lgood), .link_gigabit_i(lgig), .activity_i(act),
      .low_power_request_n_i(pin_n), .low_power_request_n_o(pin_o),
      .low_power_request_n_oe_o(pin_oe), .supply_current_alarm_n_o(al_o),
      .supply_current_alarm_n_oe_o(al_oe), .activity_indicator_i(led_i[2]),
      .activity_indicator_o(led_o[2]), .activity_indicator_oe_o(led_oe[2]),
      .gigabit_link_indicator_i(led_i[1]), .gigabit_link_indicator_o(led_o[1]),
      .gigabit_link_indicator_oe_o(led_oe[1]), .link_good_indicator_i(led_i[0]),
      .link_good_indicator_o(led_o[0]), .link_good_indicator_oe_o(led_oe[0]),
      .power_down_o(pdn), .irq_o(irq));
   pcs_board #(.STRAP(3'h5)) board (.host_pd_i(host_pd), .pin_oe_i(pin_oe),
      .led_o_i(led_o), .led_oe_i(led_oe), .pin_n_o(pin_n), .led_i_o(led_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      cyc(1);
      while (hrdy !== 1'b1) cyc(1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      dph <= !w;
      cyc(1);
      while (hrdy !== 1'b1) cyc(1);
      dph <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back({m, e});
      ahb(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic sreset;
      sys_rst_i <= 1'b1;
      cyc(3);
      sys_rst_i <= 1'b0;
      cyc(1);
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      if (dph && hrdy) begin
         cmp(hrdata & notes[0][63:32], notes[0][31:0]);
         void'(notes.pop_front());
      end
   end
   initial begin
      cyc(4000);
      n_mismatch++;
      results();
   end
   initial begin
      logic [31:0] m;
      void'($urandom(32'h65e1));
      cyc(3);
      sys_rst_i <= 1'b0;
      cyc(1);
      rd(ADDR_CTRL, 32'h0, 32'h3);
      rd(ADDR_MASK, 32'h0, 32'hf);
      rd(ADDR_STRAP, 32'h5, 32'hf);
      rd(ADDR_STATE, 32'h1, 32'h7);
      rd(8'h40, 32'h0, 32'hffffffff);
      $display("test defaults done");
      m = $urandom() & 32'hf;
      wr(ADDR_MASK, m);
      wr(8'h40, 32'hffffffff);
      rd(ADDR_MASK, m, 32'hf);
      for (int c = 0; c < 4; c++) begin
         act <= 1'($urandom());
         wr(ADDR_IOSEL, 32'(c));
         cyc(6);
         cmp({led_oe[2], led_oe[2] & led_o[2]}, {c != 3, c == 2 || (c == 0 && act)});
      end
      rd(ADDR_IOSEL, 32'h7, 32'h7);
      wr(ADDR_IOSEL, 32'h0);
      $display("test io select done");
      wr(ADDR_MASK, 32'h1);
      fault <= 1'b1;
      cyc(6);
      cmp({al_oe, al_o, irq}, 3'b101);
      fault <= 1'b0;
      cyc(6);
      cmp(al_oe, 1'b0);
      rd(ADDR_CAUSE, 32'h1, 32'h1);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      rd(ADDR_STATUS, 32'h0, 32'h1);
      cyc(1);
      cmp(irq, 1'b0);
      $display("test supply alarm done");
      for (int c = 0; c < 4; c++) begin
         lgood <= c[0];
         lgig <= c[1];
         cyc(6);
         cmp(led_o[1:0], {c[0] & c[1], c[0]});
      end
      lgood <= 1'b0;
      lgig <= 1'b0;
      $display("test indicators done");
      wr(ADDR_MASK, 32'h4);
      host_pd <= 1'b1;
      cyc(6);
      cmp({pdn, irq}, 2'b11);
      rd(ADDR_STATE, 32'h2, 32'h7);
      wr(ADDR_MASK, 32'h6);
      rd(ADDR_MASK, 32'h6, 32'hf);
      host_pd <= 1'b0;
      cyc(6);
      cmp(pdn, 1'b0);
      rd(ADDR_STATUS, 32'h4, 32'h4);
      $display("test power down done");
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_MASK, 32'h2);
      lgood <= 1'b1;
      cyc(6);
      cmp({pin_oe, pin_n}, 2'b10);
      rd(ADDR_STATUS, 32'h2, 32'h2);
      cyc(2);
      cmp(pin_oe, 1'b0);
      wr(ADDR_CTRL, 32'h0);
      lgood <= 1'b0;
      $display("test interrupt pin done");
      wr(ADDR_MASK, 32'hf);
      rst_n <= 1'b0;
      cyc(5);
      rst_n <= 1'b1;
      cyc(6);
      rd(ADDR_MASK, 32'hf, 32'hf);
      rst_n <= 1'b0;
      cyc(RST_MIN_CYC + 3);
      rst_n <= 1'b1;
      cyc(8);
      rd(ADDR_MASK, 32'h0, 32'hf);
      rd(ADDR_STATUS, 32'h8, 32'h8);
      $display("test chip reset done");
      wblk <= 1'b1;
      sreset();
      wr(ADDR_MASK, 32'hf);
      rd(ADDR_MASK, 32'h0, 32'hf);
      rd(ADDR_STRAP, 32'hd, 32'hf);
      fault <= 1'b1;
      cyc(6);
      cmp({al_oe, pin_oe, pin_n}, 3'b110);
      fault <= 1'b0;
      cyc(HOLD - 10);
      cmp({al_oe, pin_oe}, 2'b01);
      cyc(14);
      cmp(pin_oe, 1'b0);
      $display("test write block done");
      results();
   end
endmodule
